// File: rtl/lup_pkg.sv
// package: constants for the logical-layer user port arrangement
package lup_pkg;
    localparam int DATA_W = 64;
    localparam int DEST_W = 16;
    localparam int PRIO_W = 2;
    localparam int TID_W = 8;
    localparam int MAINT_ADDR_W = 24;
    // packet type field sits in bits 55:52 of the first beat of a fully-formed packet
    localparam int FTYPE_LSB = 52;
    localparam int FTYPE_W = 4;
    localparam logic [FTYPE_W-1:0] FTYPE_NREAD = 4'h2;
    localparam logic [FTYPE_W-1:0] FTYPE_WRITE = 4'h5;
    localparam logic [FTYPE_W-1:0] FTYPE_SWRITE = 4'h6;
    localparam logic [FTYPE_W-1:0] FTYPE_MAINT = 4'h8;
    localparam logic [FTYPE_W-1:0] FTYPE_DOORBELL = 4'hA;
    localparam logic [FTYPE_W-1:0] FTYPE_MESSAGE = 4'hB;
    localparam logic [FTYPE_W-1:0] FTYPE_RESPONSE = 4'hD;
    // header-split header word: ftype, prio, crf, tid, dest
    localparam int HDR_FTYPE_LSB = 60;
    localparam int HDR_PRIO_LSB = 58;
    localparam int HDR_CRF_BIT = 57;
    localparam int HDR_TID_LSB = 48;
    localparam int HDR_DEST_LSB = 32;
    localparam logic [3:0] MAINT_BYTE_EN = 4'hF;
    localparam logic [TID_W-1:0] TID_RESET = 8'h00;
    typedef enum logic [1:0] {ROUTE_IO, ROUTE_MSG, ROUTE_USER} route_e;
endpackage : lup_pkg

// File: rtl/lup_maint_req.sv
// remote maintenance request header builder with transaction id counter
module lup_maint_req
    import lup_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_req,
    input wire logic [lup_pkg::DEST_W-1:0] i_dest,
    input wire logic [lup_pkg::PRIO_W-1:0] i_prio,
    input wire logic i_crf,
    input wire logic i_write,
    output logic [lup_pkg::DATA_W-1:0] o_hdr,
    output logic o_hdr_valid
);
    import lup_pkg::*;

    logic [TID_W-1:0] tid;

    // tid advances on each request and wraps naturally at field width
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            tid <= TID_RESET;
        end else if (i_req) begin
            tid <= tid + TID_W'(1);
        end
    end

    // header fields come from the request information register, tid from the counter
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_hdr <= '0;
            o_hdr_valid <= 1'b0;
        end else begin
            o_hdr_valid <= i_req;
            if (i_req) begin
                o_hdr <= '0;
                o_hdr[HDR_FTYPE_LSB +: FTYPE_W] <= FTYPE_MAINT;
                o_hdr[HDR_PRIO_LSB +: PRIO_W] <= i_prio;
                o_hdr[HDR_CRF_BIT] <= i_crf;
                o_hdr[HDR_TID_LSB +: TID_W] <= tid;
                o_hdr[HDR_DEST_LSB +: DEST_W] <= i_dest;
                o_hdr[0] <= i_write;
            end
        end
    end
endmodule : lup_maint_req

// File: rtl/lup_user_ports.sv
// logical-layer user port router: i/o, messaging, user-defined and maintenance
module lup_user_ports
    import lup_pkg::*;
#(
    parameter bit CONDENSED_IO = 1'b1,
    parameter bit USER_PORT_EN = 1'b1,
    parameter bit MSG_ON_IO = 1'b0,
    parameter bit IO_SPLIT_FMT = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    // inbound fully-formed stream from the buffer layer
    input wire logic i_rx_valid,
    input wire logic [lup_pkg::DATA_W-1:0] i_rx_data,
    input wire logic i_rx_last,
    input wire logic [lup_pkg::PRIO_W-1:0] i_rx_prio,
    output logic o_rx_ready,
    // i/o receive channel (iorx, or treq in initiator/target form)
    output logic o_io_valid,
    output logic [lup_pkg::DATA_W-1:0] o_io_data,
    output logic o_io_last,
    output logic o_io_hdr,
    input wire logic i_io_ready,
    // initiator response channel, used only in initiator/target form
    output logic o_iresp_valid,
    output logic [lup_pkg::DATA_W-1:0] o_iresp_data,
    output logic o_iresp_last,
    input wire logic i_iresp_ready,
    // message target request channel
    output logic o_msg_valid,
    output logic [lup_pkg::DATA_W-1:0] o_msg_data,
    output logic o_msg_last,
    input wire logic i_msg_ready,
    // user-defined receive channel, fully-formed only
    output logic o_user_valid,
    output logic [lup_pkg::DATA_W-1:0] o_user_data,
    output logic o_user_last,
    input wire logic i_user_ready,
    // maintenance request in, written from the configuration side
    input wire logic i_maint_req,
    input wire logic i_maint_remote,
    input wire logic i_maint_write,
    input wire logic [lup_pkg::MAINT_ADDR_W-1:0] i_maint_addr,
    input wire logic [3:0] i_maint_strb,
    input wire logic [lup_pkg::DEST_W-1:0] i_req_dest,
    input wire logic [lup_pkg::PRIO_W-1:0] i_req_prio,
    input wire logic i_req_crf,
    output logic o_maint_err,
    // configuration master forward and remote header out
    output logic o_cfg_valid,
    output logic o_cfg_write,
    output logic [lup_pkg::MAINT_ADDR_W-1:0] o_cfg_addr,
    output logic [lup_pkg::DATA_W-1:0] o_remote_hdr,
    output logic o_remote_hdr_valid
);
    import lup_pkg::*;

    typedef enum logic [1:0] {IDLE, HDR, BODY} rx_state_e;

    rx_state_e state;
    route_e route;
    logic [DATA_W-1:0] held;
    logic held_last;
    logic [FTYPE_W-1:0] ftype;
    route_e next_route;
    logic is_resp;
    logic next_is_resp;
    logic maint_ok;
    logic sink_ready;
    logic sink_valid;
    logic held_new;
    logic to_hdr;
    logic [DATA_W-1:0] split_hdr;

    // build-time check of options: messages may only share the condensed channel
    if (!CONDENSED_IO && MSG_ON_IO) begin : g_bad_options
        $error("messages on i/o need the condensed channel in this build");
    end

    // split format emits a standard header beat first, except on the user port
    assign to_hdr = IO_SPLIT_FMT && next_route != ROUTE_USER;

    // standard header word shared by every split channel
    always_comb begin
        split_hdr = '0;
        split_hdr[HDR_FTYPE_LSB +: FTYPE_W] = ftype;
        split_hdr[HDR_PRIO_LSB +: PRIO_W] = i_rx_prio;
    end

    assign ftype = i_rx_data[FTYPE_LSB +: FTYPE_W];

    // classify the first beat; unknown types fall to the user port if present
    always_comb begin
        next_route = ROUTE_IO;
        next_is_resp = 1'b0;
        case (ftype)
            FTYPE_NREAD, FTYPE_WRITE, FTYPE_SWRITE, FTYPE_MAINT, FTYPE_DOORBELL: begin
                next_route = ROUTE_IO;
            end
            FTYPE_RESPONSE: begin
                next_route = ROUTE_IO;
                next_is_resp = !CONDENSED_IO;
            end
            FTYPE_MESSAGE: begin
                next_route = MSG_ON_IO ? ROUTE_IO : ROUTE_MSG;
            end
            default: begin
                next_route = USER_PORT_EN ? ROUTE_USER : ROUTE_IO;
            end
        endcase
    end

    // the sink chosen for the current packet
    always_comb begin
        sink_ready = 1'b0;
        case (route)
            ROUTE_IO: sink_ready = is_resp ? i_iresp_ready : i_io_ready;
            ROUTE_MSG: sink_ready = i_msg_ready;
            default: sink_ready = i_user_ready;
        endcase
    end

    assign sink_valid = o_io_valid || o_iresp_valid || o_msg_valid || o_user_valid;
    assign maint_ok = (i_maint_strb == MAINT_BYTE_EN);

    // receive sequencing: one beat held at a time, header beat first in split format except on the user port
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state <= IDLE;
            route <= ROUTE_IO;
            is_resp <= 1'b0;
            held <= '0;
            held_last <= 1'b0;
            held_new <= 1'b0;
            o_rx_ready <= 1'b0;
        end else begin
            case (state)
                IDLE: begin
                    o_rx_ready <= 1'b1;
                    if (i_rx_valid && o_rx_ready) begin
                        route <= next_route;
                        is_resp <= next_is_resp;
                        held <= i_rx_data;
                        held_last <= i_rx_last;
                        o_rx_ready <= 1'b0;
                        state <= to_hdr ? HDR : BODY;
                        // the header path sends the held beat when the header is accepted
                        held_new <= !to_hdr;
                    end
                end
                HDR: begin
                    if (sink_valid && sink_ready) begin
                        state <= BODY;
                    end
                end
                default: begin
                    if (held_new) begin
                        // fresh beat goes out on this edge; without this it would repeat
                        held_new <= 1'b0;
                    end else if (sink_valid && sink_ready) begin
                        state <= held_last ? IDLE : BODY;
                        o_rx_ready <= !held_last;
                    end else if (!sink_valid && o_rx_ready && i_rx_valid) begin
                        held <= i_rx_data;
                        held_last <= i_rx_last;
                        held_new <= 1'b1;
                        o_rx_ready <= 1'b0;
                    end
                end
            endcase
        end
    end

    // output registers; header beat packs type and priority into one layout
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_io_valid <= 1'b0;
            o_io_data <= '0;
            o_io_last <= 1'b0;
            o_io_hdr <= 1'b0;
            o_iresp_valid <= 1'b0;
            o_iresp_data <= '0;
            o_iresp_last <= 1'b0;
            o_msg_valid <= 1'b0;
            o_msg_data <= '0;
            o_msg_last <= 1'b0;
            o_user_valid <= 1'b0;
            o_user_data <= '0;
            o_user_last <= 1'b0;
        end else if (sink_valid && !sink_ready) begin
            // hold under back-pressure
        end else begin
            o_io_valid <= 1'b0;
            o_iresp_valid <= 1'b0;
            o_msg_valid <= 1'b0;
            o_user_valid <= 1'b0;
            if (i_rx_valid && o_rx_ready && state == IDLE && to_hdr) begin
                // header beat: standardized fields, payload follows later
                o_io_data <= split_hdr;
                o_msg_data <= split_hdr;
                o_io_hdr <= 1'b1;
                o_io_last <= 1'b0;
                o_msg_last <= 1'b0;
                o_io_valid <= (next_route == ROUTE_IO) && !next_is_resp;
                o_iresp_valid <= (next_route == ROUTE_IO) && next_is_resp;
                o_iresp_data <= split_hdr;
                o_iresp_last <= 1'b0;
                o_msg_valid <= next_route == ROUTE_MSG;
            end else if ((state == BODY && held_new) || state == HDR) begin
                // fully-formed beat, sent as held; i_rx_prio is not passed on with it
                o_io_hdr <= 1'b0;
                o_io_data <= held;
                o_io_last <= held_last;
                o_iresp_data <= held;
                o_iresp_last <= held_last;
                o_msg_data <= held;
                o_msg_last <= held_last;
                o_user_data <= held;
                o_user_last <= held_last;
                o_io_valid <= route == ROUTE_IO && !is_resp;
                o_iresp_valid <= route == ROUTE_IO && is_resp;
                o_msg_valid <= route == ROUTE_MSG;
                o_user_valid <= route == ROUTE_USER && USER_PORT_EN;
            end
        end
    end

    // maintenance forward: only full-word accesses reach the configuration master
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_cfg_valid <= 1'b0;
            o_cfg_write <= 1'b0;
            o_cfg_addr <= '0;
            o_maint_err <= 1'b0;
        end else begin
            o_cfg_valid <= i_maint_req && maint_ok;
            o_maint_err <= i_maint_req && !maint_ok;
            if (i_maint_req) begin
                o_cfg_write <= i_maint_write;
                o_cfg_addr <= i_maint_addr;
            end
        end
    end

    // remote requests get their header built from the information register
    lup_maint_req u_maint_req (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_req(i_maint_req && maint_ok && i_maint_remote),
        .i_dest(i_req_dest),
        .i_prio(i_req_prio),
        .i_crf(i_req_crf),
        .i_write(i_maint_write),
        .o_hdr(o_remote_hdr),
        .o_hdr_valid(o_remote_hdr_valid)
    );
endmodule : lup_user_ports

// File: bench/lup_user_ports_properties.sv
// checker: port-level properties of the user port router
module lup_user_ports_checker
    import lup_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_maint_req,
    input wire logic i_maint_remote,
    input wire logic i_maint_write,
    input wire logic [lup_pkg::MAINT_ADDR_W-1:0] i_maint_addr,
    input wire logic [3:0] i_maint_strb,
    input wire logic [lup_pkg::DEST_W-1:0] i_req_dest,
    input wire logic [lup_pkg::PRIO_W-1:0] i_req_prio,
    input wire logic i_req_crf,
    input wire logic o_maint_err,
    input wire logic o_cfg_valid,
    input wire logic o_cfg_write,
    input wire logic [lup_pkg::MAINT_ADDR_W-1:0] o_cfg_addr,
    input wire logic [lup_pkg::DATA_W-1:0] o_remote_hdr,
    input wire logic o_remote_hdr_valid,
    input wire logic o_user_valid,
    input wire logic [lup_pkg::DATA_W-1:0] o_user_data,
    input wire logic i_user_ready,
    input wire logic o_rx_ready,
    input wire logic o_io_valid,
    input wire logic o_iresp_valid,
    input wire logic o_msg_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    logic good;
    logic seen;
    logic [TID_W-1:0] last_tid;
    assign good = i_maint_req && i_maint_strb == MAINT_BYTE_EN;
    // last header tid; cleared by reset so the first header expects the reset value
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            seen <= 1'b0;
            last_tid <= TID_RESET;
        end else if (o_remote_hdr_valid) begin
            seen <= 1'b1;
            last_tid <= o_remote_hdr[HDR_TID_LSB +: TID_W];
        end
    end
    property p_bad; i_maint_req && !good |=> o_maint_err && !o_cfg_valid; endproperty
    a_bad: assert property (p_bad) else $error("bad strobe not refused");
    property p_good; good |=> !o_maint_err && o_cfg_valid; endproperty
    a_good: assert property (p_good) else $error("good request not forwarded");
    property p_fwd; good |=> o_cfg_write == $past(i_maint_write) && o_cfg_addr == $past(i_maint_addr);
    endproperty
    a_fwd: assert property (p_fwd) else $error("forwarded access differs");
    property p_idle; !i_maint_req |=> !o_cfg_valid && !o_maint_err && !o_remote_hdr_valid; endproperty
    a_idle: assert property (p_idle) else $error("spurious maintenance output");
    property p_rem; good && i_maint_remote |=> o_remote_hdr_valid && o_remote_hdr[0] == $past(i_maint_write);
    endproperty
    a_rem: assert property (p_rem) else $error("remote header missing");
    property p_loc; good && !i_maint_remote |=> !o_remote_hdr_valid; endproperty
    a_loc: assert property (p_loc) else $error("local access made a header");
    property p_fld; good && i_maint_remote |=> o_remote_hdr[HDR_DEST_LSB +: DEST_W] == $past(i_req_dest)
        && o_remote_hdr[HDR_PRIO_LSB +: PRIO_W] == $past(i_req_prio)
        && o_remote_hdr[HDR_CRF_BIT] == $past(i_req_crf); endproperty
    a_fld: assert property (p_fld) else $error("header fields differ");
    property p_tid; o_remote_hdr_valid |-> o_remote_hdr[HDR_TID_LSB +: TID_W]
        == (seen ? TID_W'(last_tid + 1'b1) : TID_RESET); endproperty
    a_tid: assert property (p_tid) else $error("tid not stepped");
    property p_hold; o_user_valid && !i_user_ready |=> o_user_valid && $stable(o_user_data); endproperty
    a_hold: assert property (p_hold) else $error("user beat dropped");
    property p_one; $onehot0({o_io_valid, o_iresp_valid, o_msg_valid, o_user_valid})
        && !(o_rx_ready && (o_io_valid || o_iresp_valid || o_msg_valid || o_user_valid));
    endproperty
    a_one: assert property (p_one) else $error("more than one beat in flight");
    c_rem: cover property (good && i_maint_remote);
    c_err: cover property (o_maint_err);
    c_user: cover property (o_user_valid && !i_user_ready);
endmodule : lup_user_ports_checker

bind lup_user_ports lup_user_ports_checker u_chk (.i_clk, .i_resetn, .i_maint_req,
    .i_maint_remote, .i_maint_write, .i_maint_addr, .i_maint_strb, .i_req_dest, .i_req_prio,
    .i_req_crf, .o_maint_err, .o_cfg_valid, .o_cfg_write, .o_cfg_addr, .o_remote_hdr,
    .o_remote_hdr_valid, .o_user_valid, .o_user_data, .i_user_ready, .o_rx_ready, .o_io_valid,
    .o_iresp_valid, .o_msg_valid);

// File: bench/user_app_model.sv
// partner model: user sinks with stalls and the request information register
module user_app_model
    import lup_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_stall,
    input wire logic i_load,
    input wire logic [lup_pkg::DEST_W-1:0] i_dest,
    input wire logic [lup_pkg::PRIO_W-1:0] i_prio,
    input wire logic i_crf,
    output logic o_ready,
    output logic [lup_pkg::DEST_W-1:0] o_dest,
    output logic [lup_pkg::PRIO_W-1:0] o_prio,
    output logic o_crf
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] phase;
    // free phase counter; sinks drop ready two cycles in eight when stalling
    always_ff @(posedge i_clk) begin
        phase <= i_resetn ? phase + 3'h1 : 3'h0;
    end
    assign o_ready = !i_stall || phase[2:1] != 2'h3;
    // header fields change only when rewritten; one write serves many requests
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            {o_dest, o_prio, o_crf} <= '0;
        end else if (i_load) begin
            {o_dest, o_prio, o_crf} <= {i_dest, i_prio, i_crf};
        end
    end
endmodule : user_app_model

// File: bench/tb_top.sv
// testbench: reference model comparison for the user port router
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lup_pkg::*;
    logic i_clk = 1'b0, i_resetn = 1'b0, stall = 1'b0, load = 1'b0, crf_in = 1'b0;
    logic rx_valid = 1'b0, rx_last = 1'b0, mreq = 1'b0, mrem = 1'b0, mwr = 1'b0;
    logic [DATA_W-1:0] rx_data = '0, io_d, usr_d, msg_d, hdr;
    logic [PRIO_W-1:0] rx_prio = '0, prio_in = '0, prio;
    logic [MAINT_ADDR_W-1:0] maddr = '0, cfg_a;
    logic [DEST_W-1:0] dest_in = '0, dest;
    logic [3:0] mstrb = 4'hF;
    logic ready, crf, rx_ready, io_v, io_h, msg_v, usr_v, err, cfg_v, cfg_w, hdr_v;
    logic io_l, iresp_v, msg_l, usr_l;
    int errors = 0, total_checks = 0, seed = 84, tid = 0;
    // packet types and expected route: 0 user, 1 message, 2 i/o
    logic [3:0] ft_tab[6] = '{4'h3, 4'h7, 4'hB, 4'h2, 4'h5, 4'hD};
    int route_tab[6] = '{0, 0, 1, 2, 2, 2};
    always #5 i_clk = ~i_clk;
    user_app_model u_app (.i_clk(i_clk), .i_resetn(i_resetn), .i_stall(stall), .i_load(load),
        .i_dest(dest_in), .i_prio(prio_in), .i_crf(crf_in), .o_ready(ready), .o_dest(dest),
        .o_prio(prio), .o_crf(crf));
    lup_user_ports dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_rx_valid(rx_valid),
        .i_rx_data(rx_data), .i_rx_last(rx_last), .i_rx_prio(rx_prio), .o_rx_ready(rx_ready),
        .o_io_valid(io_v), .o_io_data(io_d), .o_io_last(io_l), .o_io_hdr(io_h), .i_io_ready(ready),
        .o_iresp_valid(iresp_v), .o_iresp_data(), .o_iresp_last(), .i_iresp_ready(ready),
        .o_msg_valid(msg_v), .o_msg_data(msg_d), .o_msg_last(msg_l), .i_msg_ready(ready),
        .o_user_valid(usr_v), .o_user_data(usr_d), .o_user_last(usr_l), .i_user_ready(ready),
        .i_maint_req(mreq), .i_maint_remote(mrem), .i_maint_write(mwr), .i_maint_addr(maddr),
        .i_maint_strb(mstrb), .i_req_dest(dest), .i_req_prio(prio), .i_req_crf(crf),
        .o_maint_err(err), .o_cfg_valid(cfg_v), .o_cfg_write(cfg_w), .o_cfg_addr(cfg_a),
        .o_remote_hdr(hdr), .o_remote_hdr_valid(hdr_v));
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    // reset restarts the tid model too
    task automatic do_reset();
        i_resetn = 1'b0;
        mreq = 1'b0;
        tid = 0;
        repeat (12) @(posedge i_clk);
        #1 i_resetn = 1'b1;
        @(posedge i_clk);
        #1;
    endtask : do_reset
    task automatic wait_on(input logic busy);
        if (busy) begin
            errors++;
            stop_test();
        end
    endtask : wait_on
    // one single-beat packet; route 0 user, 1 message, 2 i/o
    task automatic send(input logic [3:0] ft, input int route);
        logic [DATA_W-1:0] d;
        int n;
        d = {$random(seed), $random(seed)};
        d[FTYPE_LSB +: FTYPE_W] = ft;
        {rx_valid, rx_data, rx_last, rx_prio} = {1'b1, d, 1'b1, 2'($random(seed))};
        for (n = 0; !rx_ready && n < 50; n++) @(posedge i_clk) #1;
        wait_on(n >= 50);
        @(posedge i_clk) #1 rx_valid = 1'b0;
        for (n = 0; !(usr_v || msg_v || io_v) && n < 50; n++) @(posedge i_clk) #1;
        wait_on(n >= 50);
        chk("user valid", route == 0, usr_v);
        chk("msg valid", route == 1, msg_v);
        chk("io header", route == 2, io_v && io_h);
        if (route != 0) begin
            chk("hdr ftype prio", {ft, rx_prio},
                route == 2 ? io_d[63:58] : msg_d[63:58]);
            // body beat follows on the edge that takes the header
            for (n = 0; !ready && n < 50; n++) @(posedge i_clk) #1;
            wait_on(n >= 50);
            @(posedge i_clk) #1;
        end
        chk("body valid", {route == 0, route == 1, route == 2, 1'b0},
            {usr_v, msg_v, io_v && !io_h, iresp_v});
        chk("body data", d, route == 0 ? usr_d : route == 1 ? msg_d : io_d);
        chk("body last", 1'b1, route == 0 ? usr_l : route == 1 ? msg_l : io_l);
        for (n = 0; (usr_v || msg_v || io_v) && n < 50; n++) @(posedge i_clk) #1;
        wait_on(n >= 50);
    endtask : send
    task automatic set_info();
        {mreq, load, dest_in, prio_in, crf_in} = {2'b01, 19'($random(seed))};
        @(posedge i_clk) #1 load = 1'b0;
    endtask : set_info
    // request is held high across back-to-back calls; caller lowers it
    task automatic maint(input logic rem, input logic [3:0] s);
        logic bad;
        {mreq, mrem, mstrb, mwr, maddr} = {1'b1, rem, s, 25'($random(seed))};
        bad = s != MAINT_BYTE_EN;
        @(posedge i_clk) #1;
        chk("err cfg hdr", {bad, !bad, rem && !bad}, {err, cfg_v, hdr_v});
        if (!bad) chk("cfg access", {mwr, maddr}, {cfg_w, cfg_a});
        if (rem && !bad) begin
            chk("hdr", {dest_in, prio_in, crf_in, 8'(tid), mwr}, {hdr[HDR_DEST_LSB +: DEST_W],
                hdr[HDR_PRIO_LSB +: PRIO_W], hdr[HDR_CRF_BIT], hdr[HDR_TID_LSB +: TID_W],
                hdr[0]});
            tid = (tid + 1) % (1 << TID_W);
        end
    endtask : maint
    initial begin
        logic [3:0] s;
        do_reset();
        for (int p = 0; p < 2; p++) begin
            stall = p[0];
            foreach (route_tab[k]) send(ft_tab[k], route_tab[k]);
        end
        $display("routing test done");
        // enough good remote requests to carry the tid past its wrap
        for (int i = 0; i < 400; i++) begin
            if (i % 64 == 0) set_info();
            s = (i % 7 == 3) ? 4'($random(seed)) & 4'h7 : MAINT_BYTE_EN;
            maint(i % 5 != 1, s);
        end
        $display("maintenance test done");
        do_reset();
        // reset clears the information register too, so it is written again
        set_info();
        repeat (3) maint(1'b1, MAINT_BYTE_EN);
        mreq = 1'b0;
        $display("reset restart test done");
        stop_test();
    end
endmodule : tb_top
